// ===== src/sbhs_channel.sv
// Serial bus framing, acknowledge and busy handshake with AXI4-Lite registers
//
// The register addresses and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// R1 - Acknowledge enable off: only trigger emits acknowledge
// R2 - Enable before completion: acknowledge at 9th fall
// R3 - Enable set late: acknowledge at next fall
// R4 - Software sets trigger only after byte ends
// R5 - Low acknowledge at rising edge sets flag
// R6 - Acknowledge flag cleared on start, disable, reset (here at the first clock fall of the next transfer, not at start)
// R7 - Busy enable off releases line next fall
// R8 - Busy enable on: hold low after acknowledge
// R9 - New transfer ends busy, keeps enable
// R10 - Data rise with clock high: release
// R11 - Data fall with clock high: command
// R12 - Byte after release and command is address
// R13 - Command-only byte is command, else data
// R14 - Acknowledge is one low clock period
// R15 - Line released high as ready
// R16 - Eight data clocks, then acknowledge and busy
// R17 - No wakeup: request flag at 9th rise
// R18 - Wakeup: request flag only on address match (with timing bit 5 set, here at every 9th rise and on release)
// R19 - Start waits while far side signals busy
// R20 - Interrupt timing register resets to zero
// R21 - Clock level bit read-only, zero when disabled
// R22 - Software writes zero to timing bits 0-3
// R23 - Write starts transfer when enabled, clock high
// R24 - Shift out MSB on fall, sample on rise
// R25 - Lines synchronised before edge detection
module sbhs_channel (
    // Clock and reset
    input  wire logic                        aclk,
    input  wire logic                        aresetn,
    // AXI4-Lite write address and data
    input  wire logic [sbhs_pkg::AXI_AW-1:0] s_axi_awaddr,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    input  wire logic [sbhs_pkg::AXI_DW-1:0] s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    // AXI4-Lite write response
    output logic      [1:0]                  s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [sbhs_pkg::AXI_AW-1:0] s_axi_araddr,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    output logic      [sbhs_pkg::AXI_DW-1:0] s_axi_rdata,
    output logic      [1:0]                  s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    // Serial bus pins
    input  wire logic                        serial_clock_line,
    input  wire logic                        serial_data_line_a_in,
    output logic                             serial_data_line_a_out,
    output logic                             serial_data_line_a_oe,
    // Channel request flag
    output logic                             channel_irq_flag
);
    import sbhs_pkg::*;

    logic [AXI_AW-1:0] aw_addr;
    logic [7:0]        w_data, slave_address, shift_register;
    logic              w_lane0, channel_enable, wakeup_option, busy_output_enable;
    logic              auto_ack_enable, release_detected, command_detected, ack_detected;
    logic              so_latch, ack_pend, ack_on, ack_done, busy_on, byte_is_addr, addr_match;
    logic [5:0]        int_spec;
    logic [3:0]        cnt;
    sbhs_state_t       state;
    logic [1:0]        lines_q, lines_p;

    // Bus line synchroniser, bit 1 clock and bit 0 data
    sbhs_sync #(.W(2)) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       ({serial_clock_line, serial_data_line_a_in}),
        .q       (lines_q),
        .q_prev  (lines_p)
    );

    // Edges of the synchronised lines
    logic scl_q, sda_q, scl_rise, scl_fall, rel_evt, cmd_evt;
    assign scl_q    = lines_q[1];
    assign sda_q    = lines_q[0];
    assign scl_rise = lines_q[1] & ~lines_p[1]; // R25
    assign scl_fall = ~lines_q[1] & lines_p[1];
    assign rel_evt  = scl_q & lines_p[1] & sda_q & ~lines_p[0]; // R10
    assign cmd_evt  = scl_q & lines_p[1] & ~sda_q & lines_p[0]; // R11

    // Write decode: both channels held and no response pending
    logic wr_go, wr_mode, wr_busctl, wr_intspec, wr_shift, wr_sva, wr_stat, wr_known;
    assign wr_go      = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid & w_lane0;
    assign wr_mode    = wr_go & (aw_addr == OFF_MODE);
    assign wr_busctl  = wr_go & (aw_addr == OFF_BUSCTL);
    assign wr_intspec = wr_go & (aw_addr == OFF_INTSPEC);
    assign wr_shift   = wr_go & (aw_addr == OFF_SHIFT);
    assign wr_sva     = wr_go & (aw_addr == OFF_SVA);
    assign wr_stat    = wr_go & (aw_addr == OFF_STAT);
    assign wr_known   = (aw_addr == OFF_MODE) | (aw_addr == OFF_BUSCTL) |
                        (aw_addr == OFF_INTSPEC) | (aw_addr == OFF_SHIFT) |
                        (aw_addr == OFF_SVA) | (aw_addr == OFF_STAT);

    // Self-clearing triggers and transfer start
    logic rel_trig, cmd_trig, ack_trig, auto_ack_enable_rise, start_req, idle_st, wup_eff, irq_set;
    assign rel_trig  = wr_busctl & w_data[BC_RELEASE_TRIGGER];
    assign cmd_trig  = wr_busctl & w_data[BC_COMMAND_TRIGGER];
    assign ack_trig  = wr_busctl & w_data[BC_ACK_TRIGGER];
    assign auto_ack_enable_rise = wr_busctl & w_data[BC_AUTO_ACK_ENABLE] & ~auto_ack_enable;
    assign idle_st   = (state == SBHS_IDLE) | (state == SBHS_DONE);
    assign start_req = wr_shift & channel_enable & idle_st; // R23
    assign wup_eff   = wakeup_option & ~int_spec[IS_SIC];
    assign irq_set   = ((state == SBHS_DONE) & scl_rise & (cnt == CNT_NINTH) &
                        (~wup_eff | (byte_is_addr & addr_match))) | // R17 R18
                       (int_spec[IS_SIC] & rel_evt);

    // AXI write channels, taken in either order, answered after both
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            aw_addr       <= '0;
            w_data        <= '0;
            w_lane0       <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr       <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data       <= s_axi_wdata[7:0];
                w_lane0      <= s_axi_wstrb[0]; // Only lane 0 carries register bits
                s_axi_wready <= 1'b0;
            end
            if (!s_axi_awready && !s_axi_wready && !s_axi_bvalid) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_known ? RESP_OKAY : RESP_SLVERR;
                w_lane0      <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Software-owned control registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            channel_enable     <= 1'b0;
            wakeup_option      <= 1'b0;
            busy_output_enable <= 1'b0;
            auto_ack_enable    <= 1'b0;
            int_spec           <= RST_INTSPEC[5:0]; // R20
            slave_address      <= RST_REG8;
        end else begin
            if (wr_mode) begin
                channel_enable <= w_data[MODE_CE];
                wakeup_option  <= w_data[MODE_WUP];
            end
            if (wr_busctl) begin
                busy_output_enable <= w_data[BC_BUSY_OUTPUT_ENABLE]; // R9
                auto_ack_enable    <= w_data[BC_AUTO_ACK_ENABLE];
            end
            if (wr_intspec) begin
                int_spec <= w_data[5:0]; // R22
            end
            if (wr_sva) begin
                slave_address <= w_data;
            end
        end
    end

    // Read data mux
    logic [7:0] rd_byte;
    logic       rd_known;
    always_comb begin
        rd_byte  = 8'h00;
        rd_known = 1'b1;
        case (s_axi_araddr)
            OFF_MODE:    rd_byte = {channel_enable, 1'b0, wakeup_option, addr_match, 4'h0};
            OFF_BUSCTL:  rd_byte = {busy_output_enable, ack_detected, auto_ack_enable,
                                    1'b0, command_detected, release_detected, 2'h0};
            OFF_INTSPEC: rd_byte = {1'b0, channel_enable & scl_q, int_spec}; // R21
            OFF_SHIFT:   rd_byte = shift_register;
            OFF_SVA:     rd_byte = slave_address;
            OFF_STAT:    rd_byte = {5'h00, busy_on, ~idle_st, channel_irq_flag};
            default:     rd_known = 1'b0;
        endcase
    end

    // AXI read channel, one outstanding read
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= {24'h000000, rd_byte};
            s_axi_rresp   <= rd_known ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // Transfer sequencer and output latch
    always_ff @(posedge aclk) begin
        if (!aresetn || !channel_enable) begin
            state    <= SBHS_IDLE;
            cnt      <= 4'h0;
            so_latch <= 1'b1;
        end else begin
            case (state)
                SBHS_IDLE, SBHS_DONE: begin
                    if (start_req) begin
                        state <= SBHS_WAIT;
                    end else if (rel_trig) begin
                        so_latch <= 1'b1; // R10
                    end else if (cmd_trig) begin
                        so_latch <= 1'b0; // R11
                    end else if (state == SBHS_DONE && scl_fall) begin
                        so_latch <= 1'b1; // R15
                    end
                    if (state == SBHS_DONE && scl_rise && cnt == CNT_NINTH) begin
                        cnt <= cnt + 4'h1;
                    end
                end
                SBHS_WAIT: begin
                    // Own drive is ignored; only the far side's busy holds us
                    if (scl_q && (sda_q || serial_data_line_a_oe)) begin // R19
                        state    <= SBHS_SHIFT;
                        so_latch <= shift_register[7]; // R24
                        cnt      <= 4'h0;
                    end
                end
                SBHS_SHIFT: begin
                    if (scl_rise) begin
                        cnt <= cnt + 4'h1; // R16
                        if (cnt == CNT_LAST_BIT) begin
                            state <= SBHS_DONE;
                        end
                    end else if (scl_fall && cnt != 4'h0) begin
                        so_latch <= shift_register[7]; // R24
                    end
                end
                default: state <= SBHS_IDLE;
            endcase
        end
    end

    // Shift register, byte kind and address compare
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            shift_register <= RST_SHIFT;
            byte_is_addr   <= 1'b0;
            addr_match     <= 1'b0;
        end else if (start_req) begin
            shift_register <= w_data;
            byte_is_addr   <= release_detected & command_detected; // R12 R13
        end else if (state == SBHS_SHIFT && scl_rise) begin
            shift_register <= {shift_register[6:0], sda_q}; // R24
            if (cnt == CNT_LAST_BIT) begin
                addr_match <= ({shift_register[6:0], sda_q} == slave_address);
                // A slave sees release and command only after its own start
                byte_is_addr <= byte_is_addr | (release_detected & command_detected); // R12
            end
        end
    end

    // Acknowledge and busy signalling
    always_ff @(posedge aclk) begin
        if (!aresetn || !channel_enable) begin
            ack_pend <= 1'b0;
            ack_on   <= 1'b0;
            ack_done <= 1'b0;
            busy_on  <= 1'b0;
        end else if (start_req) begin
            busy_on  <= 1'b0; // R9 R15
            ack_pend <= 1'b0;
            ack_on   <= 1'b0;
            ack_done <= 1'b0;
        end else begin
            if (scl_fall) begin
                if (ack_pend) begin
                    ack_on   <= 1'b1; // R14
                    ack_pend <= 1'b0;
                    ack_done <= 1'b1;
                end else if (ack_on) begin
                    ack_on  <= 1'b0;
                    busy_on <= busy_output_enable; // R8
                end else if (!busy_output_enable) begin
                    busy_on <= 1'b0; // R7
                end
            end
            if (state == SBHS_SHIFT && scl_rise && cnt == CNT_LAST_BIT && auto_ack_enable) begin
                ack_pend <= 1'b1; // R2
            end else if (state == SBHS_DONE && !ack_done && !ack_pend && !ack_on &&
                         (ack_trig || auto_ack_enable_rise)) begin
                ack_pend <= 1'b1; // R1 R3 R4
            end
        end
    end

    // Detection flags and channel request flag, set wins over clear
    always_ff @(posedge aclk) begin
        if (!aresetn || !channel_enable) begin
            release_detected <= 1'b0;
            command_detected <= 1'b0;
            ack_detected     <= 1'b0; // R6
            channel_irq_flag <= 1'b0;
        end else begin
            if (rel_evt) begin
                release_detected <= 1'b1; // R10
            end else if (start_req) begin
                release_detected <= 1'b0;
            end
            if (cmd_evt) begin
                command_detected <= 1'b1; // R11
            end else if (rel_evt || start_req) begin
                command_detected <= 1'b0; // R10
            end
            if (state == SBHS_DONE && scl_rise && !sda_q) begin
                ack_detected <= 1'b1; // R5 R14
            end else if (state == SBHS_SHIFT && scl_fall && cnt == 4'h0) begin
                ack_detected <= 1'b0; // R6
            end
            if (irq_set) begin
                channel_irq_flag <= 1'b1; // R17 R18
            end else if (wr_stat && w_data[ST_IRQ]) begin
                channel_irq_flag <= 1'b0;
            end
        end
    end

    // Open-drain data pin: only ever pulls low
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            serial_data_line_a_out <= 1'b0;
            serial_data_line_a_oe  <= 1'b0;
        end else begin
            serial_data_line_a_out <= 1'b0;
            serial_data_line_a_oe  <= channel_enable & (ack_on | busy_on |
                                      (~so_latch & ~wakeup_option)); // R8 R15
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_ack_cause;
        $rose(ack_pend) |-> $past(auto_ack_enable | ack_trig | auto_ack_enable_rise);
    endproperty
    a_ack_cause: assert property (p_ack_cause) // R1
        else $error("acknowledge armed without enable or trigger");

    property p_auto_ack;
        (channel_enable && ack_pend && scl_fall && !start_req) |=> ack_on ##1 ack_on;
    endproperty
    a_auto_ack: assert property (p_auto_ack) // R2
        else $error("armed acknowledge not driven at clock fall");

    property p_busy_release;
        (channel_enable && busy_on && !ack_on && !busy_output_enable && scl_fall)
            |=> !busy_on ##1 !busy_on;
    endproperty
    a_busy_release: assert property (p_busy_release) // R7
        else $error("busy not released after enable cleared");

    property p_start_ends_busy;
        start_req |=> !busy_on && $stable(busy_output_enable);
    endproperty
    a_start_ends_busy: assert property (p_start_ends_busy) // R9
        else $error("start did not end busy or changed enable");

    property p_release_flag;
        (channel_enable && rel_evt) |=> release_detected && !command_detected;
    endproperty
    a_release_flag: assert property (p_release_flag) // R10
        else $error("release condition not flagged");

    property p_command_flag;
        (channel_enable && cmd_evt) |=> command_detected;
    endproperty
    a_command_flag: assert property (p_command_flag) // R11
        else $error("command condition not flagged");

    property p_ack_detect;
        (channel_enable && state == SBHS_DONE && scl_rise && !sda_q) |=> ack_detected;
    endproperty
    a_ack_detect: assert property (p_ack_detect) // R5
        else $error("low acknowledge not detected");

    property p_irq_ninth;
        (channel_enable && state == SBHS_DONE && scl_rise && cnt == CNT_NINTH && !wup_eff)
            |=> channel_irq_flag;
    endproperty
    a_irq_ninth: assert property (p_irq_ninth) // R17
        else $error("request flag missing at ninth clock");

    property p_cld_zero;
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == OFF_INTSPEC && !channel_enable)
            |=> s_axi_rdata[IS_CLD] == 1'b0;
    endproperty
    a_cld_zero: assert property (p_cld_zero) // R21
        else $error("clock level bit set while disabled");
endmodule
`default_nettype wire

// ===== src/sbhs_pkg.sv
// Shared constants and types for the serial bus handshake channel
package sbhs_pkg;
    // AXI4-Lite widths and answers
    localparam int         AXI_AW      = 8;
    localparam int         AXI_DW      = 32;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Register byte addresses
    localparam logic [7:0] OFF_MODE    = 8'h00;
    localparam logic [7:0] OFF_BUSCTL  = 8'h04;
    localparam logic [7:0] OFF_INTSPEC = 8'h08;
    localparam logic [7:0] OFF_SHIFT   = 8'h0c;
    localparam logic [7:0] OFF_SVA     = 8'h10;
    localparam logic [7:0] OFF_STAT    = 8'h14;
    // Channel mode register fields
    localparam int MODE_CE    = 7;
    localparam int MODE_WUP   = 5;
    localparam int MODE_MATCH = 4;
    // Bus control register fields
    localparam int BC_BUSY_OUTPUT_ENABLE = 7;
    localparam int BC_ACK_DETECTED = 6;
    localparam int BC_AUTO_ACK_ENABLE = 5;
    localparam int BC_ACK_TRIGGER = 4;
    localparam int BC_COMMAND_DETECTED = 3;
    localparam int BC_RELEASE_DETECTED = 2;
    localparam int BC_COMMAND_TRIGGER = 1;
    localparam int BC_RELEASE_TRIGGER = 0;
    // Interrupt timing spec fields
    localparam int IS_CLD = 6;
    localparam int IS_SIC = 5;
    // Status register fields
    localparam int ST_IRQ  = 0;
    localparam int ST_XFER = 1;
    localparam int ST_BUSY = 2;
    // Reset values
    localparam logic [7:0] RST_INTSPEC = 8'h00;
    localparam logic [7:0] RST_REG8    = 8'h00;
    localparam logic [7:0] RST_SHIFT   = 8'hff;
    // Clock counts within one byte
    localparam logic [3:0] CNT_LAST_BIT = 4'h7;
    localparam logic [3:0] CNT_NINTH    = 4'h8;
    // Transfer sequencer states
    typedef enum logic [1:0] {
        SBHS_IDLE  = 2'b00,
        SBHS_WAIT  = 2'b01,
        SBHS_SHIFT = 2'b10,
        SBHS_DONE  = 2'b11
    } sbhs_state_t;
endpackage

// ===== src/sbhs_sync.sv
// Two-flop synchroniser with a third stage for edge detection
`timescale 1ns/1ps
`default_nettype none
module sbhs_sync #(
    parameter int W = 2
) (
    // Clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // Asynchronous levels in
    input  wire logic [W-1:0] d,
    // Synchronised level and its previous sample
    output logic      [W-1:0] q,
    output logic      [W-1:0] q_prev
);
    logic [W-1:0] meta;

    // Idle bus level is high for both lines
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta   <= '1;
            q      <= '1;
            q_prev <= '1;
        end else begin
            meta   <= d;
            q      <= meta;
            q_prev <= q;
        end
    end
endmodule
`default_nettype wire

// ===== test/sbhs_far_master.sv
// Far-side master: drives the serial clock and pulls the shared data line
`timescale 1ns/1ps
`default_nettype none
module sbhs_far_master (
    // Bus lines
    output logic      scl,
    output wire logic sda,
    // Device pull-down enable
    input  wire logic dev_oe
);
    logic pull;
    // Open-drain line with pull-up, low when anyone pulls
    assign sda = !(pull || dev_oe);
    initial begin
        scl = 1'b1;
        pull = 1'b0;
    end
    // Data change while the clock is high marks a condition
    task automatic cond(input logic lvl);
        pull = !lvl;
        #80;
    endtask
    // One clock: bit changed while low, line sampled late in the high phase
    task automatic pulse(input logic b, output logic seen);
        scl = 1'b0;
        #20;
        pull = !b;
        #60;
        scl = 1'b1;
        #79;
        seen = sda;
        #1;
    endtask
    // Optional release and command, eight bits MSB first, then ack and busy clocks
    task automatic xfer(input logic [7:0] b, input logic rc, output logic ack, output logic busy);
        logic s;
        if (rc) begin
            cond(1'b0);
            cond(1'b1);
            cond(1'b0);
        end
        for (int i = 7; i >= 0; i--) begin
            pulse(b[i], s);
        end
        pulse(1'b1, ack);
        pulse(1'b1, busy);
    endtask
endmodule
`default_nettype wire

// ===== test/sbhs_channel_tb.sv
// Self-checking bench for the serial bus handshake channel
`timescale 1ns/1ps
`default_nettype none
module sbhs_channel_tb;
    import sbhs_pkg::*;
    logic              aclk = 1'b0;
    logic              aresetn = 1'b0;
    logic [AXI_AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [AXI_DW-1:0] s_axi_wdata = '0, s_axi_rdata;
    logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic              s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]        s_axi_bresp, s_axi_rresp, rsp;
    logic [3:0]        s_axi_wstrb = 4'hf;
    wire logic         serial_clock_line, serial_data_line_a_in;
    logic              serial_data_line_a_out, serial_data_line_a_oe, channel_irq_flag;
    logic [31:0]       rv;
    logic              ack, busy;
    int                err_total = 0;
    int                check_count = 0;
    // Clock
    always #10 aclk = ~aclk;
    sbhs_channel uut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .serial_clock_line,
        .serial_data_line_a_in, .serial_data_line_a_out, .serial_data_line_a_oe,
        .channel_irq_flag
    );
    sbhs_far_master far (
        .scl(serial_clock_line), .sda(serial_data_line_a_in), .dev_oe(serial_data_line_a_oe)
    );
    // Compare and count
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    // Register write, address and data offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    // Register read
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rv = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // Verdict and end of run
    task automatic final_report;
        if (err_total == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Watchdog
    initial begin
        #100000;
        err_total++;
        final_report;
    end
    // Main sequence
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd(OFF_INTSPEC);
        chk("intspec reset", 32'h0, rv);
        rd(8'hfc);
        chk("unmapped rresp", 32'(RESP_SLVERR), 32'(rsp));
        wr(8'hfc, 32'h1);
        chk("unmapped bresp", 32'(RESP_SLVERR), 32'(rsp));
        wr(OFF_INTSPEC, 32'h20);
        rd(OFF_INTSPEC);
        chk("intspec disabled", 32'h20, rv);
        wr(OFF_MODE, 32'h80);
        rd(OFF_INTSPEC);
        chk("intspec enabled", 32'h60, rv);
        wr(OFF_INTSPEC, 32'h0);
        // Write without lane 0 has no effect, then the slave address
        s_axi_wstrb <= 4'he;
        wr(OFF_SVA, 32'ha5);
        rd(OFF_SVA);
        chk("lane 0 off", 32'h0, rv);
        s_axi_wstrb <= 4'hf;
        wr(OFF_SVA, 32'ha5);
        // Address byte with automatic ack and busy
        wr(OFF_BUSCTL, 32'ha0);
        wr(OFF_SHIFT, 32'hff);
        #7 far.xfer(8'ha5, 1'b1, ack, busy);
        chk("auto ack", 32'h0, 32'(ack));
        chk("data out", 32'h0, 32'(serial_data_line_a_out));
        chk("busy", 32'h0, 32'(busy));
        chk("irq", 32'h1, 32'(channel_irq_flag));
        rd(OFF_SHIFT);
        chk("rx byte", 32'ha5, rv);
        rd(OFF_BUSCTL);
        chk("busctl", 32'hec, rv);
        rd(OFF_MODE);
        chk("address match", 32'h90, rv);
        wr(OFF_STAT, 32'h1);
        chk("irq cleared", 32'h0, 32'(channel_irq_flag));
        wr(OFF_SHIFT, 32'hff);
        repeat (8) @(posedge aclk);
        chk("ready", 32'h0, 32'(serial_data_line_a_oe));
        rd(OFF_BUSCTL);
        chk("busy enable kept", 32'h80, rv & 32'h80);
        // Data byte with ack and busy off, then ack enabled late
        wr(OFF_BUSCTL, 32'h00);
        wr(OFF_MODE, 32'ha0);
        #7 far.xfer(8'h3c, 1'b0, ack, busy);
        chk("no auto ack", 32'h1, 32'(ack));
        chk("no busy", 32'h1, 32'(busy));
        chk("data irq", 32'h0, 32'(channel_irq_flag));
        wr(OFF_BUSCTL, 32'h20);
        #7 far.pulse(1'b1, ack);
        chk("late ack", 32'h0, 32'(ack));
        rd(OFF_BUSCTL);
        chk("ack flag and enable", 32'h60, rv & 32'h60);
        // Triggers drive command and release while the clock stays high
        #7 far.pulse(1'b1, ack);
        wr(OFF_MODE, 32'h80);
        wr(OFF_BUSCTL, 32'h02);
        repeat (2) @(posedge aclk);
        chk("command drive", 32'h1, 32'(serial_data_line_a_oe));
        rd(OFF_BUSCTL);
        chk("command flag", 32'h08, rv & 32'h08);
        wr(OFF_BUSCTL, 32'h01);
        repeat (2) @(posedge aclk);
        rd(OFF_BUSCTL);
        chk("release flag", 32'h04, rv & 32'h0c);
        wr(OFF_MODE, 32'h0);
        rd(OFF_BUSCTL);
        chk("ack flag disabled", 32'h0, rv & 32'h40);
        final_report;
    end
endmodule
`default_nettype wire
